/* hdl/cfm_framer.sv */
// Primary-rate trunk framer: frame, signalling multiframe and CRC-4
// Overview of operation
// - 32 slots of 8 bits, repeating
// - Slots 1-15, 17-31 carry 30 channels
// - Common channel mode: slot 16 carries data
// - Slot 0 alternates alignment and non-alignment words
// - Alignment word bits 2-8 are 0011011
// - Non-alignment bit 2 is 1, bit 3 alarm
// - Frame 0 slot 16 upper quartet zeros
// - Frames 1-15 slot 16 carry channel signalling
// - CRC remainder of half times x^4
// - Two eight-frame halves checked independently
// - Alignment word bit 1 carries C1..C4
// - Odd frames 1-11 carry pattern 001011
// - Half remainder inserted in next half
// - Receiver compares remainder, counts errored halves
// - Frames 13/15 report first/second half result
// - Received alignment bit 1 taken as CRC
// - Report mux sends results in frames 13/15
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cfm_framer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transmit channel source
  input wire logic [7:0] tx_chan_data,
  output logic tx_req,
  output logic [4:0] tx_req_slot,
  output logic [3:0] tx_req_frame,
  // Trunk transmit
  output logic tx_line_clk,
  output logic tx_line_data,
  // Trunk receive
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  // Received channel sink
  output logic [7:0] rx_byte,
  output logic [4:0] rx_slot,
  output logic [3:0] rx_frame,
  output logic rx_valid
);
  // ********************************************
  // Register bus
  // ********************************************
  logic [12:0] ctrl_r, ctrl_nxt;
  logic ah_wr_r, ah_wr_nxt;
  logic [7:0] ah_addr_r, ah_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic ah_take, cnt_clear;
  logic [7:0] stat;
  logic [7:0] err_cnt_r;
  logic [3:0] rx_frm_r;
  logic rx_lock_r, rx_mflock_r, rx_err1_r, rx_err2_r;

  assign stat = {rx_frm_r, ~rx_err2_r, ~rx_err1_r, rx_mflock_r, rx_lock_r};
  assign ah_take = hsel && hready && htrans[1];
  assign cnt_clear = ah_wr_r && (ah_addr_r == cfm_pkg::ADDR_ERRCNT);

  always_comb begin
    ah_wr_nxt = ah_take && hwrite;
    ah_addr_nxt = ah_take ? haddr[7:0] : ah_addr_r;
    hrdata_nxt = hrdata_r;
    ctrl_nxt = ctrl_r;
    if (ah_take && !hwrite) begin
      unique case (haddr[7:0])
        cfm_pkg::ADDR_CTRL: hrdata_nxt = {19'h0, ctrl_r};
        cfm_pkg::ADDR_STAT: hrdata_nxt = {24'h0, stat};
        cfm_pkg::ADDR_ERRCNT: hrdata_nxt = {24'h0, err_cnt_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
    if (ah_wr_r && (ah_addr_r == cfm_pkg::ADDR_CTRL)) begin
      ctrl_nxt = hwdata[12:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= cfm_pkg::CTRL_RST;
      ah_wr_r <= 1'b0;
      ah_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ah_wr_r <= ah_wr_nxt;
      ah_addr_r <= ah_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Zero wait states, so the slave never stalls the bus
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  logic crc_en, ccs_en, mux_en;
  assign crc_en = ctrl_r[cfm_pkg::CTL_CRC];
  assign ccs_en = ctrl_r[cfm_pkg::CTL_CCS];
  assign mux_en = ctrl_r[cfm_pkg::CTL_MUX];

  // ********************************************
  // Transmit framer
  // ********************************************
  logic [2:0] tx_div_r, tx_div_nxt, tx_bit_r, tx_bit_nxt;
  logic [4:0] tx_ts_r, tx_ts_nxt, nts, tx_rslot_r, tx_rslot_nxt;
  logic [3:0] tx_frm_r, tx_frm_nxt, nfrm, tx_rfrm_r, tx_rfrm_nxt;
  logic [7:0] tx_shift_r, tx_shift_nxt, tx_byte;
  logic [3:0] tx_hold_r, tx_hold_nxt, c_src, tx_rem, tx_rem_nxt;
  logic tx_req_r, tx_req_nxt, tx_clk_r, tx_clk_nxt, tx_dat_r, tx_dat_nxt;
  logic tx_stb, tx_load, tx_b1, tx_mask, tx_smf_start, tx_smf_end;

  assign tx_stb = (tx_div_r == cfm_pkg::TX_DIV_M1);
  assign tx_load = tx_stb && (tx_bit_r == cfm_pkg::BIT_LAST);
  assign nts = tx_ts_r + 5'h01;
  assign nfrm = (tx_ts_r == cfm_pkg::TS_LAST) ? tx_frm_r + 4'h1 : tx_frm_r;
  // Bit cell now on the line: first bit of an alignment word
  assign tx_mask = (tx_ts_r == cfm_pkg::TS_ZERO) && (tx_bit_r == 3'h0) && !tx_frm_r[0];
  assign tx_smf_start = tx_mask && (tx_frm_r[2:0] == cfm_pkg::SMF_START);
  assign tx_smf_end = tx_load && (nts == cfm_pkg::TS_ZERO)
                      && (nfrm[2:0] == cfm_pkg::SMF_START);
  // C1 goes out before the last bit of the previous half has settled
  assign c_src = (nfrm[2:0] == cfm_pkg::SMF_START) ? tx_rem_nxt : tx_hold_r;

  cfm_crc4 u_tx_crc (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(tx_stb),
    .clr(tx_smf_start),
    .din(tx_mask ? 1'b0 : tx_shift_r[7]),
    .rem(tx_rem),
    .rem_nxt(tx_rem_nxt)
  );

  always_comb begin
    tx_b1 = 1'b1;
    if (!nfrm[0]) begin
      if (crc_en) begin
        tx_b1 = c_src[~nfrm[2:1]];
      end
    end else if (crc_en) begin
      if (nfrm == cfm_pkg::FRM_SI1) begin
        tx_b1 = mux_en ? ~rx_err1_r : 1'b1;
      end else if (nfrm == cfm_pkg::FRM_SI2) begin
        tx_b1 = mux_en ? ~rx_err2_r : 1'b1;
      end else begin
        tx_b1 = cfm_pkg::MFA_PAT[cfm_pkg::MFA_TOP - nfrm[3:1]];
      end
    end
    if (nts == cfm_pkg::TS_ZERO) begin
      if (!nfrm[0]) begin
        tx_byte = {tx_b1, cfm_pkg::FAS_PAT};
      end else begin
        tx_byte = {tx_b1, 1'b1, ctrl_r[cfm_pkg::CTL_ALARM],
                   ctrl_r[cfm_pkg::CTL_NAT_HI:cfm_pkg::CTL_NAT_LO]};
      end
    end else if ((nts == cfm_pkg::TS_SIG) && !ccs_en && (nfrm == cfm_pkg::FRM_ZERO)) begin
      tx_byte = {cfm_pkg::MF_ZEROS, ctrl_r[cfm_pkg::CTL_XY_HI:cfm_pkg::CTL_XY_LO]};
    end else begin
      // Data slots, slot 16 signalling pairs, or slot 16 data in CCS
      tx_byte = tx_chan_data;
    end
  end

  always_comb begin
    tx_div_nxt = tx_stb ? 3'h0 : tx_div_r + 3'h1;
    tx_clk_nxt = (tx_div_nxt < cfm_pkg::TX_DIV_HALF);
    tx_bit_nxt = tx_bit_r;
    tx_ts_nxt = tx_ts_r;
    tx_frm_nxt = tx_frm_r;
    tx_shift_nxt = tx_shift_r;
    tx_dat_nxt = tx_dat_r;
    tx_hold_nxt = tx_smf_end ? tx_rem_nxt : tx_hold_r;
    tx_req_nxt = tx_stb && (tx_bit_r == cfm_pkg::BIT_PRE);
    tx_rslot_nxt = tx_req_nxt ? nts : tx_rslot_r;
    tx_rfrm_nxt = tx_req_nxt ? nfrm : tx_rfrm_r;
    if (tx_load) begin
      tx_bit_nxt = 3'h0;
      tx_ts_nxt = nts;
      tx_frm_nxt = nfrm;
      tx_shift_nxt = tx_byte;
      tx_dat_nxt = tx_byte[7];
    end else if (tx_stb) begin
      tx_bit_nxt = tx_bit_r + 3'h1;
      tx_shift_nxt = {tx_shift_r[6:0], 1'b0};
      tx_dat_nxt = tx_shift_r[6];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_div_r <= 3'h0;
      tx_clk_r <= 1'b1;
      tx_bit_r <= cfm_pkg::BIT_LAST;
      tx_ts_r <= cfm_pkg::TS_LAST;
      tx_frm_r <= cfm_pkg::FRM_SI2;
      tx_shift_r <= 8'hFF;
      tx_dat_r <= 1'b1;
      tx_hold_r <= 4'h0;
      tx_req_r <= 1'b0;
      tx_rslot_r <= 5'h00;
      tx_rfrm_r <= 4'h0;
    end else begin
      tx_div_r <= tx_div_nxt;
      tx_clk_r <= tx_clk_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_ts_r <= tx_ts_nxt;
      tx_frm_r <= tx_frm_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_dat_r <= tx_dat_nxt;
      tx_hold_r <= tx_hold_nxt;
      tx_req_r <= tx_req_nxt;
      tx_rslot_r <= tx_rslot_nxt;
      tx_rfrm_r <= tx_rfrm_nxt;
    end
  end

  assign tx_line_clk = tx_clk_r;
  assign tx_line_data = tx_dat_r;
  assign tx_req = tx_req_r;
  assign tx_req_slot = tx_rslot_r;
  assign tx_req_frame = tx_rfrm_r;

  // ********************************************
  // Receive deframer
  // ********************************************
  logic [1:0] rx_pins;
  logic rx_clk_d_r, rx_tick, rx_end, rx_mask, rx_smf, rx_mis, rx_inc;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [4:0] rx_ts_r, rx_ts_nxt, rx_slot_r, rx_slot_nxt;
  logic [3:0] rx_frm_nxt, rx_frame_r, rx_frame_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt, rx_full, rx_byte_r, rx_byte_nxt;
  logic [7:0] err_cnt_nxt;
  logic [5:0] rx_mfsr_r, rx_mfsr_nxt;
  logic [3:0] rx_cb_r, rx_cb_nxt, rx_hold_r, rx_hold_nxt, rx_rem, rx_rem_nxt;
  logic rx_lock_nxt, rx_mflock_nxt, rx_hok_r, rx_hok_nxt, rx_pri_r, rx_pri_nxt;
  logic rx_err1_nxt, rx_err2_nxt, rx_valid_r, rx_valid_nxt;

  cfm_sync2 #(.WIDTH(2)) u_rx_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({rx_line_clk, rx_line_data}),
    .dout(rx_pins)
  );

  // Line data is centred on the falling edge of the line clock
  assign rx_tick = rx_clk_d_r && !rx_pins[1];
  assign rx_full = {rx_shift_r[6:0], rx_pins[0]};
  assign rx_end = rx_tick && rx_lock_r && (rx_bit_r == cfm_pkg::BIT_LAST);
  assign rx_mask = (rx_ts_r == cfm_pkg::TS_ZERO) && (rx_bit_r == 3'h0) && !rx_frm_r[0];
  assign rx_smf = rx_tick && rx_mflock_r && rx_mask
                  && (rx_frm_r[2:0] == cfm_pkg::SMF_START);
  assign rx_mis = rx_hok_r && (rx_cb_r != rx_hold_r);
  assign rx_inc = rx_smf && rx_mis;

  cfm_crc4 u_rx_crc (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(rx_tick && rx_lock_r),
    .clr(rx_smf),
    .din(rx_mask ? 1'b0 : rx_pins[0]),
    .rem(rx_rem),
    .rem_nxt(rx_rem_nxt)
  );

  always_comb begin
    rx_bit_nxt = rx_bit_r;
    rx_ts_nxt = rx_ts_r;
    rx_frm_nxt = rx_frm_r;
    rx_shift_nxt = rx_tick ? rx_full : rx_shift_r;
    rx_lock_nxt = rx_lock_r;
    rx_mflock_nxt = rx_mflock_r;
    rx_mfsr_nxt = rx_mfsr_r;
    rx_cb_nxt = rx_cb_r;
    rx_hold_nxt = rx_hold_r;
    rx_hok_nxt = rx_hok_r;
    rx_pri_nxt = rx_pri_r;
    rx_err1_nxt = rx_err1_r;
    rx_err2_nxt = rx_err2_r;
    rx_valid_nxt = rx_end;
    rx_byte_nxt = rx_end ? rx_full : rx_byte_r;
    rx_slot_nxt = rx_end ? rx_ts_r : rx_slot_r;
    rx_frame_nxt = rx_end ? rx_frm_r : rx_frame_r;
    // Set wins over a software clear in the same cycle
    err_cnt_nxt = (cnt_clear ? 8'h00 : err_cnt_r) + (rx_inc ? 8'h01 : 8'h00);
    if (rx_smf) begin
      // Result lands on the half that the new half matches
      if (rx_hok_r && (rx_frm_r[3] == 1'b0)) begin
        rx_err1_nxt = rx_mis;
      end else if (rx_hok_r) begin
        rx_err2_nxt = rx_mis;
      end
      rx_hold_nxt = rx_rem;
      // Remainder before the first boundary spans an unaligned half
      rx_hok_nxt = rx_pri_r;
      rx_pri_nxt = 1'b1;
    end
    if (rx_tick && !rx_lock_r) begin
      if (rx_full[6:0] == cfm_pkg::FAS_PAT) begin
        rx_lock_nxt = 1'b1;
        rx_bit_nxt = 3'h0;
        rx_ts_nxt = cfm_pkg::TS_ZERO + 5'h01;
        rx_frm_nxt = {rx_frm_r[3:1], 1'b0};
      end
    end else if (rx_tick) begin
      rx_bit_nxt = rx_bit_r + 3'h1;
      if (rx_bit_r == cfm_pkg::BIT_LAST) begin
        rx_ts_nxt = rx_ts_r + 5'h01;
        rx_frm_nxt = (rx_ts_r == cfm_pkg::TS_LAST) ? rx_frm_r + 4'h1 : rx_frm_r;
      end
      if (rx_end && (rx_ts_r == cfm_pkg::TS_ZERO) && !rx_frm_r[0]) begin
        if (rx_full[6:0] != cfm_pkg::FAS_PAT) begin
          rx_lock_nxt = 1'b0;
          rx_mflock_nxt = 1'b0;
          rx_hok_nxt = 1'b0;
          rx_pri_nxt = 1'b0;
        end
        rx_cb_nxt[~rx_frm_r[2:1]] = rx_full[7];
      end else if (rx_end && (rx_ts_r == cfm_pkg::TS_ZERO)) begin
        rx_mfsr_nxt = {rx_mfsr_r[4:0], rx_full[7]};
        if (crc_en && !rx_mflock_r && (rx_mfsr_nxt == cfm_pkg::MFA_PAT)) begin
          rx_mflock_nxt = 1'b1;
          rx_frm_nxt = cfm_pkg::FRM_MFA_LAST;
        end else if (rx_mflock_r && (rx_frm_r == cfm_pkg::FRM_MFA_LAST)
                     && (!crc_en || (rx_mfsr_nxt != cfm_pkg::MFA_PAT))) begin
          rx_mflock_nxt = 1'b0;
          rx_hok_nxt = 1'b0;
          rx_pri_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_clk_d_r <= 1'b0;
      rx_bit_r <= 3'h0;
      rx_ts_r <= 5'h00;
      rx_frm_r <= 4'h0;
      rx_shift_r <= 8'h00;
      rx_lock_r <= 1'b0;
      rx_mflock_r <= 1'b0;
      rx_mfsr_r <= 6'h00;
      rx_cb_r <= 4'h0;
      rx_hold_r <= 4'h0;
      rx_hok_r <= 1'b0;
      rx_pri_r <= 1'b0;
      rx_err1_r <= 1'b0;
      rx_err2_r <= 1'b0;
      err_cnt_r <= 8'h00;
      rx_valid_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_slot_r <= 5'h00;
      rx_frame_r <= 4'h0;
    end else begin
      rx_clk_d_r <= rx_pins[1];
      rx_bit_r <= rx_bit_nxt;
      rx_ts_r <= rx_ts_nxt;
      rx_frm_r <= rx_frm_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_lock_r <= rx_lock_nxt;
      rx_mflock_r <= rx_mflock_nxt;
      rx_mfsr_r <= rx_mfsr_nxt;
      rx_cb_r <= rx_cb_nxt;
      rx_hold_r <= rx_hold_nxt;
      rx_hok_r <= rx_hok_nxt;
      rx_pri_r <= rx_pri_nxt;
      rx_err1_r <= rx_err1_nxt;
      rx_err2_r <= rx_err2_nxt;
      err_cnt_r <= err_cnt_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_slot_r <= rx_slot_nxt;
      rx_frame_r <= rx_frame_nxt;
    end
  end

  assign rx_valid = rx_valid_r;
  assign rx_byte = rx_byte_r;
  assign rx_slot = rx_slot_r;
  assign rx_frame = rx_frame_r;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_slot_wrap: assert property (tx_load && (tx_ts_r == 5'h1F) |=> (tx_ts_r == 5'h00) && (tx_frm_r == $past(tx_frm_r) + 4'h1)) else $error("slot count did not wrap");
  chk_fas_word: assert property (tx_load && (nts == 5'h00) && !nfrm[0] |=> tx_shift_r[6:0] == 7'h1B) else $error("alignment word wrong");
  chk_nfas_fixed: assert property (tx_load && (nts == 5'h00) && nfrm[0] |=> tx_shift_r[6] && (tx_shift_r[5] == ctrl_r[3])) else $error("non-alignment word wrong");
  chk_mf_zeros: assert property (tx_load && (nts == 5'h10) && (nfrm == 4'h0) && !ccs_en |=> tx_shift_r[7:4] == 4'h0) else $error("multiframe zeros missing");
  chk_ccs_pass: assert property (tx_load && (nts == 5'h10) && ccs_en |=> tx_shift_r == $past(tx_chan_data)) else $error("slot 16 not passed in common channel mode");
  chk_crc_insert: assert property (tx_load && (nts == 5'h00) && !nfrm[0] && crc_en && (nfrm[2:0] != 3'h0) |=> tx_shift_r[7] == tx_hold_r[~tx_frm_r[2:1]]) else $error("check bit not from held remainder");
  chk_si_first: assert property (tx_load && (nts == 5'h00) && (nfrm == 4'hD) && crc_en && mux_en |=> tx_shift_r[7] == !rx_err1_r) else $error("first half report wrong");
  chk_mfa_first: assert property (tx_load && (nts == 5'h00) && (nfrm == 4'h1) && crc_en |=> !tx_shift_r[7]) else $error("alignment pattern bit wrong");
  chk_err_count: assert property (rx_inc && !cnt_clear |=> err_cnt_r == $past(err_cnt_r) + 8'h01) else $error("errored half not counted");
  chk_lock_loss: assert property (rx_end && (rx_ts_r == 5'h00) && !rx_frm_r[0] && (rx_full[6:0] != 7'h1B) |=> !rx_lock_r && !rx_mflock_r) else $error("lock kept on bad word");
endmodule : cfm_framer

/* hdl/cfm_pkg.sv */
// Constants shared by the trunk framer design files
package cfm_pkg;
  // ********************************************
  // Timing
  // ********************************************
  localparam int CLK_MHZ = 10;
  localparam int LINE_BIT_NS = 488;
  localparam int TX_DIV_CYC = (LINE_BIT_NS * CLK_MHZ) / 1000;
  localparam logic [2:0] TX_DIV_M1 = 3'(TX_DIV_CYC - 1);
  localparam logic [2:0] TX_DIV_HALF = 3'(TX_DIV_CYC / 2);
  // ********************************************
  // Frame structure
  // ********************************************
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_PRE = 3'h6;
  localparam logic [4:0] TS_ZERO = 5'h00;
  localparam logic [4:0] TS_SIG = 5'h10;
  localparam logic [4:0] TS_LAST = 5'h1F;
  localparam logic [3:0] FRM_ZERO = 4'h0;
  localparam logic [3:0] FRM_MFA_LAST = 4'hB;
  localparam logic [3:0] FRM_SI1 = 4'hD;
  localparam logic [3:0] FRM_SI2 = 4'hF;
  localparam logic [2:0] SMF_START = 3'h0;
  localparam logic [2:0] MFA_TOP = 3'h5;
  localparam logic [6:0] FAS_PAT = 7'h1B;
  localparam logic [5:0] MFA_PAT = 6'h0B;
  localparam logic [3:0] MF_ZEROS = 4'h0;
  localparam logic [3:0] CRC_POLY = 4'h3;
  // ********************************************
  // Register map and fields
  // ********************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_ERRCNT = 8'h08;
  localparam int CTL_W = 13;
  localparam int CTL_CRC = 0;
  localparam int CTL_CCS = 1;
  localparam int CTL_MUX = 2;
  localparam int CTL_ALARM = 3;
  localparam int CTL_NAT_LO = 4;
  localparam int CTL_NAT_HI = 8;
  localparam int CTL_XY_LO = 9;
  localparam int CTL_XY_HI = 12;
  localparam logic [12:0] CTRL_RST = 13'h1FF0;
endpackage : cfm_pkg

/* hdl/cfm_sync2.sv */
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module cfm_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_r;
  logic [WIDTH-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= '0;
      dout_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;
endmodule : cfm_sync2

/* hdl/cfm_crc4.sv */
// Serial CRC-4 remainder engine, message times x^4 over x^4+x+1
`timescale 1ns/1ps
module cfm_crc4 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bit stream
  input wire logic en,
  input wire logic clr,
  input wire logic din,
  // Remainder
  output logic [3:0] rem,
  output logic [3:0] rem_nxt
);
  logic [3:0] rem_r;
  logic [3:0] base;
  logic [3:0] step_nxt;

  always_comb begin
    // Clear folds into the first bit so no cell of the half is lost
    base = clr ? 4'h0 : rem_r;
    step_nxt = rem_r;
    if (en) begin
      step_nxt = {base[2:0], 1'b0} ^ ((din ^ base[3]) ? cfm_pkg::CRC_POLY : 4'h0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rem_r <= 4'h0;
    end else begin
      rem_r <= step_nxt;
    end
  end

  assign rem = rem_r;
  assign rem_nxt = step_nxt;
endmodule : cfm_crc4

/* verification/cfm_far_end.sv */
// Far-end trunk model: framed line stream with CRC-4 check bits
`timescale 1ns/1ps
module cfm_far_end (
  // Control
  input wire logic corrupt,
  // Trunk toward the framer
  output logic line_clk,
  output logic line_data
);
  logic [3:0] acc;
  logic [3:0] hold;
  logic [7:0] v;
  logic [5:0] mfa;
  logic d;
  // ********************************
  // Line generator
  // ********************************
  initial begin
    line_clk = 1'b0;
    line_data = 1'b1;
    acc = 4'h0;
    hold = 4'h0;
    mfa = 6'b001011;
    // Odd start offset keeps the link unrelated in phase to the system clock
    #137;
    forever for (int f = 0; f < 16; f++) for (int s = 0; s < 32; s++) begin
      if (s == 0 && f % 8 == 0) begin
        hold = acc;
        acc = 4'h0;
      end
      if (s == 0 && f % 2 == 0) v = {hold[3 - (f / 2) % 4] ^ corrupt, 7'h1B};
      else if (s == 0) v = {(f > 11) ? 1'b1 : mfa[5 - f / 2], 2'b10, 5'h1F};
      else if (s == 16 && f == 0) v = 8'h0B;
      else v = 8'(f * 16) ^ 8'(s);
      for (int b = 7; b >= 0; b--) begin
        // Data moves on the rising edge so the falling edge meets mid-bit
        line_data = v[b];
        line_clk = 1'b1;
        #400;
        line_clk = 1'b0;
        #400;
        d = v[b] & !(s == 0 && b == 7 && f % 2 == 0);
        acc = {acc[2:0], 1'b0} ^ ((acc[3] ^ d) ? 4'h3 : 4'h0);
      end
    end
  end
endmodule : cfm_far_end

/* verification/tb.sv */
// Testbench: register access, transmit framing and receive CRC checks
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} cfm_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] tx_chan_data = 8'h00;
  logic hreadyout, hresp, tx_req, tx_line_clk, tx_line_data, rx_line_clk, rx_line_data, rx_valid;
  logic [31:0] hrdata, rd;
  logic [4:0] tx_req_slot, rx_slot, ps, cs;
  logic [3:0] tx_req_frame, rx_frame, pf, cf;
  logic [7:0] rx_byte, tb_b;
  logic corrupt = 1'b0;
  logic rx_on = 1'b0;
  logic pend = 1'b0;
  logic [12:0] ctrl = 13'h1FF0;
  logic [3:0] acc = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [5:0] mfa = 6'b001011;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int rpt_zero = 0;
  int n_half = 0;
  int bn = 0;
  cfm_row_t rows [6] = '{'{1'b0, 8'h00, 32'h0, 32'h1FF0}, '{1'b1, 8'h00, 32'h1FF7, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'h1FF7}, '{1'b1, 8'h0C, 32'hFFFF, 32'h0},
    '{1'b0, 8'h0C, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0}};

  always #50 clk_sys = ~clk_sys;

  cfm_framer i_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_chan_data(tx_chan_data), .tx_req(tx_req),
    .tx_req_slot(tx_req_slot), .tx_req_frame(tx_req_frame), .tx_line_clk(tx_line_clk),
    .tx_line_data(tx_line_data), .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data),
    .rx_byte(rx_byte), .rx_slot(rx_slot), .rx_frame(rx_frame), .rx_valid(rx_valid));
  cfm_far_end i_far (.corrupt(corrupt), .line_clk(rx_line_clk), .line_data(rx_line_data));

  // ********************************
  // Shared tasks
  // ********************************
  function automatic logic [7:0] pat(input logic [4:0] s, input logic [3:0] f);
    return {f, 4'h0} ^ {3'h0, s};
  endfunction : pat

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (wr && a == 8'h00) ctrl = wd[12:0];
  endtask : ahb

  task automatic tx_check();
    logic [7:0] e;
    logic [7:0] m;
    e = pat(cs, cf);
    m = 8'hFF;
    if (cs == 5'h00 && !cf[0]) begin
      e = {hold[3 - cf[2:1]], 7'h1B};
      if (!ctrl[0] || n_half < 2) m = 8'h7F;
    end else if (cs == 5'h00) begin
      e = {mfa[5 - cf[3:1]], 1'b1, ctrl[3], ctrl[8:4]};
      if (!ctrl[0] || cf > 4'hB) m = 8'h7F;
      if (cf > 4'hB && tb_b[7] === 1'b0) rpt_zero++;
    end else if (cs == 5'h10 && cf == 4'h0 && !ctrl[1]) e = {4'h0, ctrl[12:9]};
    chk("tx_slot_byte", {24'h0, tb_b & m}, {24'h0, e & m});
  endtask : tx_check

  // ********************************
  // Channel source and monitors
  // ********************************
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 99000) begin
      bad_count++;
      end_sim();
    end
    if (tx_req === 1'b1) begin
      tx_chan_data <= pat(tx_req_slot, tx_req_frame);
      ps = tx_req_slot;
      pf = tx_req_frame;
      pend = 1'b1;
    end
    if (rx_on && rx_valid === 1'b1) begin
      if (rx_slot == 5'h00) chk("rx_align", {31'h0, rx_frame[0] ? rx_byte[6] : rx_byte[6:0] == 7'h1B},
        32'h1);
      else chk("rx_chan", {24'h0, rx_byte}, (rx_slot == 5'h10 && rx_frame == 4'h0) ? 32'h0B :
        {24'h0, pat(rx_slot, rx_frame)});
    end
  end

  // Slot starts on the first line clock rise after its request
  always @(posedge tx_line_clk) if (pend) begin
    pend = 1'b0;
    cs = ps;
    cf = pf;
    bn = 8;
    if (ps == 5'h00 && pf[2:0] == 3'h0) begin
      hold = acc;
      acc = 4'h0;
      n_half++;
    end
  end

  always @(negedge tx_line_clk) if (bn > 0) begin
    bn--;
    tb_b[bn] = tx_line_data;
    acc = {acc[2:0], 1'b0} ^ ((acc[3] ^ (tx_line_data & !(cs == 5'h00 && bn == 7 && !cf[0])))
      ? 4'h3 : 4'h0);
    if (bn == 0) tx_check();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      ahb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("reg_read", rd, rows[i].e);
    end
    rd = 32'h0;
    while (rd[1] !== 1'b1) begin
      repeat (1000) @(posedge clk_sys);
      ahb(1'b0, 8'h04, 32'h0);
    end
    chk("status_lock", {30'h0, rd[1:0]}, 32'h3);
    rx_on = 1'b1;
    ahb(1'b1, 8'h00, 32'h1FF5);
    // Let stale error reports drain before the clean window
    repeat (17000) @(posedge clk_sys);
    ahb(1'b1, 8'h08, 32'h0);
    rpt_zero = 0;
    repeat (17000) @(posedge clk_sys);
    ahb(1'b0, 8'h08, 32'h0);
    chk("errcnt_clean", rd, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_clean", {28'h0, rd[3:0]}, 32'hF);
    chk("report_clean", rpt_zero, 32'h0);
    corrupt <= 1'b1;
    repeat (30000) @(posedge clk_sys);
    ahb(1'b0, 8'h08, 32'h0);
    chk("errcnt_bad", {31'h0, rd[7:0] != 8'h00}, 32'h1);
    chk("report_bad", {31'h0, rpt_zero > 0}, 32'h1);
    end_sim();
  end
endmodule : tb
